/* hw/rfe_frame_encoder.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// response frame encoder: fixed part, payload stream, terminators
module rfe_frame_encoder (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // frame request
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire rfe_pkg::rfe_kind_e req_kind,
  input  wire logic [15:0]        req_id,
  input  wire logic [15:0]        req_aux,
  input  wire logic               req_is_float,
  input  wire logic [31:0]        req_value,
  input  wire logic [7:0]         req_index,
  input  wire logic [7:0]         req_count,
  // touch event gating for selector feedback
  input  wire logic [2:0]         touch_event,
  input  wire logic [2:0]         touch_cfg,
  // binary time fields
  input  wire logic [15:0]        tm_hour,
  input  wire logic [15:0]        tm_minute,
  input  wire logic [15:0]        tm_second,
  input  wire logic [15:0]        tm_day,
  input  wire logic [15:0]        tm_month,
  input  wire logic [15:0]        tm_year,
  input  wire logic [15:0]        tm_weekday,
  // payload stream, bytes in the low half, wide units use all 16 bits
  input  wire logic               pay_valid,
  output logic                    pay_ready,
  input  wire logic [15:0]        pay_data,
  input  wire logic               pay_last,
  // directory entry fields, held while an entry is sent
  input  wire logic               list_end,
  input  wire logic [31:0]        ent_size,
  input  wire logic [7:0]         ent_attr,
  input  wire logic [4:0]         ent_hour,
  input  wire logic [5:0]         ent_minute,
  input  wire logic [5:0]         ent_second,
  input  wire logic [6:0]         ent_year,
  input  wire logic [3:0]         ent_month,
  input  wire logic [4:0]         ent_day,
  // byte stream to the serial transmitter
  output logic                    tx_valid,
  input  wire logic               tx_ready,
  output logic [7:0]              tx_data,
  // status pulses
  output logic                    frame_done,
  output logic                    frame_drop
);

  ////////////////////////////////////////////////////////////////////////
  // state record
  typedef struct packed {
    rfe_pkg::rfe_state_e st;
    logic [143:0]        hdr;
    logic [4:0]          hlen;
    logic [4:0]          idx;
    rfe_pkg::rfe_body_e  body;
    logic [31:0]         remain;
    logic [15:0]         word;
    logic [1:0]          wbytes;
    logic                last_unit;
    logic [1:0]          term;
    logic [7:0]          tx_data;
    logic                tx_valid;
    logic                pay_ready;
    logic                req_ready;
    logic                frame_done;
    logic                frame_drop;
  } rfe_state_s;

  rfe_state_s          r;
  rfe_state_s          n;
  logic [143:0]        hb_flat;
  logic [4:0]          hb_len;
  rfe_pkg::rfe_body_e  hb_body;
  logic [31:0]         hb_count;
  logic                hb_known;
  logic [15:0]         ent_time;
  logic [15:0]         ent_date;
  logic                slot_free;
  logic                counted;
  logic                wide;
  logic                touch_hit;

  ////////////////////////////////////////////////////////////////////////
  // fixed part layout for the pending request
  rfe_head_build u_head (
    .kind        (req_kind),
    .id16        (req_id),
    .aux16       (req_aux),
    .is_float    (req_is_float),
    .value32     (req_value),
    .index8      (req_index),
    .count8      (req_count),
    .time_fields ({tm_weekday, tm_year, tm_month, tm_day,
                   tm_second, tm_minute, tm_hour}),
    .flat        (hb_flat),
    .len         (hb_len),
    .body        (hb_body),
    .count       (hb_count),
    .known       (hb_known)
  );

  // entry stamp packing
  rfe_stamp_pack u_stamp (
    .hour            (ent_hour),
    .minute          (ent_minute),
    .second          (ent_second),
    .year_since_base (ent_year),
    .month           (ent_month),
    .day             (ent_day),
    .time_word       (ent_time),
    .date_word       (ent_date)
  );

  ////////////////////////////////////////////////////////////////////////
  // helpers
  assign slot_free = !r.tx_valid || tx_ready;
  assign counted   = (r.body == rfe_pkg::B_BYTES) ||
                     (r.body == rfe_pkg::B_WORDS);
  assign wide      = (r.body == rfe_pkg::B_WORDS) ||
                     (r.body == rfe_pkg::B_TEXT16);
  assign touch_hit = |(touch_event & touch_cfg);

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n            = r;
    n.frame_done = 1'b0;
    n.frame_drop = 1'b0;
    // the held byte leaves when the transmitter takes it
    if (tx_ready) begin
      n.tx_valid = 1'b0;
    end
    case (r.st)
      rfe_pkg::S_IDLE: begin
        n.req_ready = 1'b1;
        if (req_valid && r.req_ready) begin
          if (!hb_known ||
              (req_kind == rfe_pkg::K_SEL && !touch_hit)) begin
            n.frame_drop = 1'b1;
          end else begin
            n.st        = rfe_pkg::S_HEAD;
            n.hdr       = hb_flat;
            n.hlen      = hb_len;
            n.idx       = '0;
            n.body      = hb_body;
            n.remain    = hb_count;
            n.wbytes    = '0;
            n.req_ready = 1'b0;
          end
        end
      end
      rfe_pkg::S_HEAD, rfe_pkg::S_LREC: begin
        if (slot_free) begin
          n.tx_data  = r.hdr[{r.idx, 3'b000} +: 8];
          n.tx_valid = 1'b1;
          n.idx      = r.idx + 5'h01;
          if (r.idx == r.hlen - 5'h01) begin
            n.idx = '0;
            if (r.st == rfe_pkg::S_LREC) begin
              n.st = rfe_pkg::S_BODY;
            end else if (r.body == rfe_pkg::B_NONE ||
                         (counted && r.remain == '0)) begin
              n.st = rfe_pkg::S_FLUSH;
            end else begin
              n.st = rfe_pkg::S_BODY;
            end
          end
        end
      end
      rfe_pkg::S_BODY: begin
        if (r.wbytes != 2'h0) begin
          // drain the held unit low byte first
          if (slot_free) begin
            n.tx_data  = r.word[7:0];
            n.tx_valid = 1'b1;
            n.word     = {8'h00, r.word[15:8]};
            n.wbytes   = r.wbytes - 2'h1;
            if (r.wbytes == 2'h1 && r.last_unit) begin
              case (r.body)
                rfe_pkg::B_TEXT8, rfe_pkg::B_LIST: begin
                  n.st   = rfe_pkg::S_TERM;
                  n.term = 2'h1;
                end
                rfe_pkg::B_TEXT16: begin
                  n.st   = rfe_pkg::S_TERM;
                  n.term = 2'h2;
                end
                default: begin
                  n.st = rfe_pkg::S_FLUSH;
                end
              endcase
            end
          end
        end else if (pay_valid && r.pay_ready) begin
          // take one unit; wide units carry two bytes
          n.word   = wide ? pay_data : {8'h00, pay_data[7:0]};
          n.wbytes = wide ? 2'h2 : 2'h1;
          n.remain = r.remain - 32'h1;
          n.last_unit = counted ? (r.remain == 32'h1) : pay_last;
        end else if (r.body == rfe_pkg::B_LIST && list_end) begin
          if (slot_free) begin
            n.tx_data  = rfe_pkg::ZERO_BYTE;
            n.tx_valid = 1'b1;
            n.st       = rfe_pkg::S_FLUSH;
          end
        end
      end
      rfe_pkg::S_TERM: begin
        if (slot_free) begin
          n.tx_data  = rfe_pkg::ZERO_BYTE;
          n.tx_valid = 1'b1;
          n.term     = r.term - 2'h1;
          if (r.term == 2'h1) begin
            if (r.body == rfe_pkg::B_LIST) begin
              // entry fields follow the name
              n.st   = rfe_pkg::S_LREC;
              n.hdr  = 144'({ent_date, ent_time, ent_attr,
                             ent_size});
              n.hlen = rfe_pkg::LEN_RECORD;
              n.idx  = '0;
            end else begin
              n.st = rfe_pkg::S_FLUSH;
            end
          end
        end
      end
      rfe_pkg::S_FLUSH: begin
        // wait until the last byte is handed over
        if (slot_free) begin
          n.st         = rfe_pkg::S_IDLE;
          n.req_ready  = 1'b1;
          n.frame_done = 1'b1;
        end
      end
      default: begin
        n.st = rfe_pkg::S_IDLE;
      end
    endcase
    // registered ready: open only with an empty unit holder
    n.pay_ready = (n.st == rfe_pkg::S_BODY) && (n.wbytes == 2'h0);
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign req_ready  = r.req_ready;
  assign pay_ready  = r.pay_ready;
  assign tx_valid   = r.tx_valid;
  assign tx_data    = r.tx_data;
  assign frame_done = r.frame_done;
  assign frame_drop = r.frame_drop;

endmodule : rfe_frame_encoder

/* hw/rfe_pkg.sv */
// What this block does
// - selector change sends esc T Q C, object id, item index; only on enabled touch
// - string-file count frame is esc V S C plus one 16-bit count
// - byte string frame: esc V S A, id, length, that many bytes, no zero
// - wide string frame: esc V S U, id, length, that many 16-bit chars
// - register value frame: esc V R G, id, type I or F, 32-bit value
// - port block inventory: esc H P I, 16-bit flags, bit 0 always set
// - port read frame: esc H P R, port, count, one state byte per port
// - pin read frame: esc H B R, pin, count, one state byte per pin
// - analogue frame: esc H A R, channel, count, one 16-bit value each
// - uart, spi, i2c relay: esc H R/S/I R, 32-bit count, data bytes
// - time text frame: esc W S A or U, formatted text, zero ending
// - binary time: esc W S B, hour min sec day month year weekday
// - working directory frame: esc F D G, path, zero terminator
// - listing: esc F D R, records name size attr time date, final zero
// - entry time and date packed as modification stamp fields
// - every multi-byte field goes out least significant byte first
package rfe_pkg;

  ////////////////////////////////////////////////////////////////////////
  // frame bytes; codes hold three chars, low byte sent first
  localparam logic [7:0]  ESC_BYTE      = 8'h1b;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [23:0] CODE_SEL      = 24'h435154;
  localparam logic [23:0] CODE_STR_CNT  = 24'h435356;
  localparam logic [23:0] CODE_STR8     = 24'h415356;
  localparam logic [23:0] CODE_STR16    = 24'h555356;
  localparam logic [23:0] CODE_REGVAL   = 24'h475256;
  localparam logic [23:0] CODE_PORT_INV = 24'h495048;
  localparam logic [23:0] CODE_PORT_RD  = 24'h525048;
  localparam logic [23:0] CODE_PIN_RD   = 24'h524248;
  localparam logic [23:0] CODE_ANA_RD   = 24'h524148;
  localparam logic [23:0] CODE_UART_RLY = 24'h525248;
  localparam logic [23:0] CODE_SPI_RLY  = 24'h525348;
  localparam logic [23:0] CODE_I2C_RLY  = 24'h524948;
  localparam logic [23:0] CODE_TIME_TXT = 24'h415357;
  localparam logic [23:0] CODE_TIME_WID = 24'h555357;
  localparam logic [23:0] CODE_TIME_BIN = 24'h425357;
  localparam logic [23:0] CODE_WDIR     = 24'h474446;
  localparam logic [23:0] CODE_DIR_LIST = 24'h524446;

  ////////////////////////////////////////////////////////////////////////
  // field values
  localparam logic [15:0] TYPE_INT      = 16'h0049;
  localparam logic [15:0] TYPE_FLOAT    = 16'h0046;
  localparam logic [15:0] INV_INTERNAL  = 16'h0001;

  ////////////////////////////////////////////////////////////////////////
  // fixed part lengths in bytes
  localparam logic [4:0]  LEN_CODE_ONLY = 5'h04;
  localparam logic [4:0]  LEN_ONE16     = 5'h06;
  localparam logic [4:0]  LEN_TWO16     = 5'h08;
  localparam logic [4:0]  LEN_REGVAL    = 5'h0c;
  localparam logic [4:0]  LEN_TIME_BIN  = 5'h12;
  localparam logic [4:0]  LEN_RECORD    = 5'h09;
  localparam int          HDR_BYTES     = 18;

  ////////////////////////////////////////////////////////////////////////
  // frame kinds requested by the firmware side
  typedef enum logic [4:0] {
    K_SEL      = 5'h00,
    K_STR_CNT  = 5'h01,
    K_STR8     = 5'h02,
    K_STR16    = 5'h03,
    K_REGVAL   = 5'h04,
    K_PORT_INV = 5'h05,
    K_PORT_RD  = 5'h06,
    K_PIN_RD   = 5'h07,
    K_ANA_RD   = 5'h08,
    K_UART_RLY = 5'h09,
    K_SPI_RLY  = 5'h0a,
    K_I2C_RLY  = 5'h0b,
    K_TIME_TXT = 5'h0c,
    K_TIME_WID = 5'h0d,
    K_TIME_BIN = 5'h0e,
    K_WDIR     = 5'h0f,
    K_DIR_LIST = 5'h10
  } rfe_kind_e;

  // what follows the fixed part
  typedef enum logic [2:0] {
    B_NONE   = 3'h0,
    B_BYTES  = 3'h1,
    B_WORDS  = 3'h2,
    B_TEXT8  = 3'h3,
    B_TEXT16 = 3'h4,
    B_LIST   = 3'h5
  } rfe_body_e;

  // framer states, gray along head, body, term, flush
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_HEAD  = 3'b001,
    S_BODY  = 3'b011,
    S_TERM  = 3'b010,
    S_FLUSH = 3'b110,
    S_LREC  = 3'b111
  } rfe_state_e;

endpackage : rfe_pkg

/* hw/rfe_stamp_pack.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// packs a directory entry's modification stamp into time and date words
module rfe_stamp_pack (
  // stamp fields
  input  wire logic [4:0]  hour,
  input  wire logic [5:0]  minute,
  input  wire logic [5:0]  second,
  input  wire logic [6:0]  year_since_base,
  input  wire logic [3:0]  month,
  input  wire logic [4:0]  day,
  // packed words
  output logic      [15:0] time_word,
  output logic      [15:0] date_word
);

  // hour high, minute middle, halved second low
  assign time_word = {hour, minute, second[5:1]};
  // years since base high, month middle, day low
  assign date_word = {year_since_base, month, day};

endmodule : rfe_stamp_pack

/* hw/rfe_head_build.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// lays out the fixed part of a frame, byte 0 in the low bits
module rfe_head_build (
  // request fields
  input  wire rfe_pkg::rfe_kind_e kind,
  input  wire logic [15:0]        id16,
  input  wire logic [15:0]        aux16,
  input  wire logic               is_float,
  input  wire logic [31:0]        value32,
  input  wire logic [7:0]         index8,
  input  wire logic [7:0]         count8,
  input  wire logic [111:0]       time_fields,
  // layout
  output logic      [143:0]       flat,
  output logic      [4:0]         len,
  output rfe_pkg::rfe_body_e      body,
  output logic      [31:0]        count,
  output logic                    known
);

  logic [15:0] type16;

  assign type16 = is_float ? rfe_pkg::TYPE_FLOAT : rfe_pkg::TYPE_INT;

  // lower concatenation parts leave first, so fields are little endian
  always_comb begin
    flat  = '0;
    len   = rfe_pkg::LEN_CODE_ONLY;
    body  = rfe_pkg::B_NONE;
    count = '0;
    known = 1'b1;
    case (kind)
      rfe_pkg::K_SEL: begin
        flat = 144'({aux16, id16, rfe_pkg::CODE_SEL, rfe_pkg::ESC_BYTE});
        len  = rfe_pkg::LEN_TWO16;
      end
      rfe_pkg::K_STR_CNT: begin
        flat = 144'({aux16, rfe_pkg::CODE_STR_CNT, rfe_pkg::ESC_BYTE});
        len  = rfe_pkg::LEN_ONE16;
      end
      rfe_pkg::K_STR8, rfe_pkg::K_STR16: begin
        flat  = 144'({aux16, id16, (kind == rfe_pkg::K_STR8) ?
                 rfe_pkg::CODE_STR8 : rfe_pkg::CODE_STR16,
                 rfe_pkg::ESC_BYTE});
        len   = rfe_pkg::LEN_TWO16;
        body  = (kind == rfe_pkg::K_STR8) ? rfe_pkg::B_BYTES :
                rfe_pkg::B_WORDS;
        count = 32'(aux16);
      end
      rfe_pkg::K_REGVAL: begin
        flat = 144'({value32, type16, id16, rfe_pkg::CODE_REGVAL,
                rfe_pkg::ESC_BYTE});
        len  = rfe_pkg::LEN_REGVAL;
      end
      rfe_pkg::K_PORT_INV: begin
        flat = 144'({aux16 | rfe_pkg::INV_INTERNAL, rfe_pkg::CODE_PORT_INV,
                rfe_pkg::ESC_BYTE});
        len  = rfe_pkg::LEN_ONE16;
      end
      rfe_pkg::K_PORT_RD, rfe_pkg::K_PIN_RD, rfe_pkg::K_ANA_RD: begin
        case (kind)
          rfe_pkg::K_PORT_RD: flat = 144'({count8, index8,
                              rfe_pkg::CODE_PORT_RD, rfe_pkg::ESC_BYTE});
          rfe_pkg::K_PIN_RD:  flat = 144'({count8, index8,
                              rfe_pkg::CODE_PIN_RD, rfe_pkg::ESC_BYTE});
          default:            flat = 144'({count8, index8,
                              rfe_pkg::CODE_ANA_RD, rfe_pkg::ESC_BYTE});
        endcase
        len   = rfe_pkg::LEN_ONE16;
        body  = (kind == rfe_pkg::K_ANA_RD) ? rfe_pkg::B_WORDS :
                rfe_pkg::B_BYTES;
        count = 32'(count8);
      end
      rfe_pkg::K_UART_RLY, rfe_pkg::K_SPI_RLY, rfe_pkg::K_I2C_RLY: begin
        case (kind)
          rfe_pkg::K_UART_RLY: flat = 144'({value32,
                               rfe_pkg::CODE_UART_RLY, rfe_pkg::ESC_BYTE});
          rfe_pkg::K_SPI_RLY:  flat = 144'({value32,
                               rfe_pkg::CODE_SPI_RLY, rfe_pkg::ESC_BYTE});
          default:             flat = 144'({value32,
                               rfe_pkg::CODE_I2C_RLY, rfe_pkg::ESC_BYTE});
        endcase
        len   = rfe_pkg::LEN_TWO16;
        body  = rfe_pkg::B_BYTES;
        count = value32;
      end
      rfe_pkg::K_TIME_TXT: begin
        flat = 144'({rfe_pkg::CODE_TIME_TXT, rfe_pkg::ESC_BYTE});
        body = rfe_pkg::B_TEXT8;
      end
      rfe_pkg::K_TIME_WID: begin
        flat = 144'({rfe_pkg::CODE_TIME_WID, rfe_pkg::ESC_BYTE});
        body = rfe_pkg::B_TEXT16;
      end
      rfe_pkg::K_TIME_BIN: begin
        flat = {time_fields, rfe_pkg::CODE_TIME_BIN, rfe_pkg::ESC_BYTE};
        len  = rfe_pkg::LEN_TIME_BIN;
      end
      rfe_pkg::K_WDIR: begin
        flat = 144'({rfe_pkg::CODE_WDIR, rfe_pkg::ESC_BYTE});
        body = rfe_pkg::B_TEXT8;
      end
      rfe_pkg::K_DIR_LIST: begin
        flat = 144'({rfe_pkg::CODE_DIR_LIST, rfe_pkg::ESC_BYTE});
        body = rfe_pkg::B_LIST;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

endmodule : rfe_head_build

/* tb/rfe_assertions.sv */
`timescale 1ns/10ps
////////////////////////////////////////
// port checker for the frame encoder
module rfe_assertions (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               rst,
  // request side
  input wire logic               req_valid,
  input wire logic               req_ready,
  input wire rfe_pkg::rfe_kind_e req_kind,
  input wire logic [2:0]         touch_event,
  input wire logic [2:0]         touch_cfg,
  // transmit side and status
  input wire logic               tx_valid,
  input wire logic               tx_ready,
  input wire logic [7:0]         tx_data,
  input wire logic               frame_done,
  input wire logic               frame_drop
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic take;
  logic gate;
  // request taken, and selector touch gating
  assign take = req_valid && req_ready;
  assign gate = |(touch_event & touch_cfg);
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte changed before taken");
  a_esc_lead: assert property (
    take |=> (frame_drop or ##1 (tx_valid && tx_data == 8'h1b)))
    else $error("frame did not open with escape");
  a_drop_gate: assert property (
    take && req_kind == rfe_pkg::K_SEL && !gate |=> frame_drop && !tx_valid)
    else $error("ungated selector not dropped");
  a_sel_send: assert property (
    take && req_kind == rfe_pkg::K_SEL && gate |=> !frame_drop ##1 tx_valid)
    else $error("gated selector not sent");
  a_busy_hold: assert property (
    take |=> !req_ready || frame_drop)
    else $error("request accepted during frame");
  a_busy_tx: assert property (
    tx_valid |-> !req_ready)
    else $error("ready while bytes pending");
  a_done_ready: assert property (
    frame_done |-> req_ready && !tx_valid)
    else $error("done without idle");
  a_done_pulse: assert property (
    frame_done |=> !frame_done)
    else $error("done longer than one cycle");
endmodule : rfe_assertions

bind rfe_frame_encoder rfe_assertions CHK (
  .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
  .req_ready(req_ready), .req_kind(req_kind), .touch_event(touch_event),
  .touch_cfg(touch_cfg), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_data(tx_data), .frame_done(frame_done), .frame_drop(frame_drop));

/* tb/rfe_host_model.sv */
`timescale 1ns/10ps
// host side: takes transmit bytes, optionally stalling
module rfe_host_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // byte stream and stall control
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       slow,
  output logic            tx_ready
);
  logic [7:0] rx [$];
  logic [1:0] ph = 2'h0;
  // bytes kept in arrival order; slow mode accepts one cycle in four
  always @(posedge sys_clk) begin
    if (!rst && tx_valid && tx_ready) rx.push_back(tx_data);
    ph <= ph + 2'h1;
    tx_ready <= !rst && (!slow || ph == 2'h3);
  end
endmodule : rfe_host_model

/* tb/response_frame_encoder_test.sv */
`timescale 1ns/10ps
module response_frame_encoder_test;
  logic               sys_clk, rst = 1'b1, req_valid = 1'b0, slow = 1'b0;
  logic               req_is_float = 1'b0, lst = 1'b0, tk = 1'b0;
  logic               pay_valid = 1'b0, pay_last = 1'b0, list_end = 1'b0;
  rfe_pkg::rfe_kind_e req_kind = rfe_pkg::K_SEL;
  logic [15:0]        req_id = '0, req_aux = '0, pay_data = '0;
  logic [31:0]        req_value = '0, ent_size = '0;
  logic [7:0]         req_index = '0, req_count = '0, ent_attr = '0;
  logic [2:0]         touch_event = '0, touch_cfg = '0;
  logic [15:0]        tm [7] = '{default: '0};
  logic [32:0]        stamp = '0;
  logic               req_ready, pay_ready, tx_valid, tx_ready;
  logic               frame_done, frame_drop;
  logic [7:0]         tx_data;
  logic [16:0]        pq [$];
  logic [7:0]         ex [$];
  int                 errors = 0, cmp_count = 0, cyc = 0;

  rfe_frame_encoder DUT (
    .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_kind(req_kind), .req_id(req_id),
    .req_aux(req_aux), .req_is_float(req_is_float), .req_value(req_value),
    .req_index(req_index), .req_count(req_count),
    .touch_event(touch_event), .touch_cfg(touch_cfg),
    .tm_hour(tm[0]), .tm_minute(tm[1]), .tm_second(tm[2]), .tm_day(tm[3]),
    .tm_month(tm[4]), .tm_year(tm[5]), .tm_weekday(tm[6]),
    .pay_valid(pay_valid), .pay_ready(pay_ready), .pay_data(pay_data),
    .pay_last(pay_last), .list_end(list_end), .ent_size(ent_size),
    .ent_attr(ent_attr), .ent_hour(stamp[32:28]),
    .ent_minute(stamp[27:22]), .ent_second(stamp[21:16]),
    .ent_year(stamp[15:9]), .ent_month(stamp[8:5]), .ent_day(stamp[4:0]),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .frame_done(frame_done), .frame_drop(frame_drop));
  rfe_host_model HOST (.sys_clk(sys_clk), .rst(rst), .tx_valid(tx_valid),
    .tx_data(tx_data), .slow(slow), .tx_ready(tx_ready));

  ////////////////////////////////////////
  // clock, hang guard, payload feeder, list end
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  always @(negedge sys_clk) begin
    if (tk) void'(pq.pop_front());
    tk = pq.size() != 0 && pay_ready === 1'b1;
    pay_valid <= pq.size() != 0;
    if (pq.size() != 0) {pay_last, pay_data} <= pq[0];
    list_end <= lst && HOST.rx.size() >= 15;
  end

  ////////////////////////////////////////
  // compare, verdict, one frame
  task chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task test_done;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic frm(rfe_pkg::rfe_kind_e k, logic [15:0] id, aux,
                     logic [31:0] v, logic [15:0] ic, string pu, es);
    int n;
    @(posedge sys_clk);
    for (int i = 0; i < pu.len(); i += 4)
      pq.push_back({i + 4 >= pu.len(), 16'(pu.substr(i, i + 3).atohex())});
    for (int i = 0; i < es.len(); i += 2)
      ex.push_back(8'(es.substr(i, i + 1).atohex()));
    @(negedge sys_clk);
    req_kind = k;
    {req_id, req_aux, req_value, req_index, req_count} = {id, aux, v, ic};
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 99) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    req_valid = 1'b0;
    while (frame_done !== 1'b1 && frame_drop !== 1'b1 && n < 2999) begin
      @(negedge sys_clk);
      n++;
    end
    chk("drop", frame_drop, es == "");
    chk("done", frame_done, es != "");
    chk("count", HOST.rx.size(), ex.size());
    foreach (ex[i]) chk("byte", HOST.rx[i], ex[i]);
    HOST.rx.delete();
    ex.delete();
  endtask : frm

  ////////////////////////////////////////
  // scenarios
  task s_sel;
    touch_event = 3'h1;
    touch_cfg = 3'h3;
    frm(rfe_pkg::K_SEL, 16'h1234, 16'h5, '0, '0, "",
        "1b54514334120500");
    touch_cfg = 3'h6;
    frm(rfe_pkg::K_SEL, 16'h1234, 16'h5, '0, '0, "", "");
    frm(rfe_pkg::rfe_kind_e'(5'h1f), '0, '0, '0, '0, "", "");
  endtask : s_sel
  task s_str;
    frm(rfe_pkg::K_STR_CNT, '0, 16'h0102, '0, '0, "",
        "1b5653430201");
    slow = 1'b1;
    frm(rfe_pkg::K_STR8, 16'h7, 16'h2, '0, '0, "00410042",
        "1b565341070002004142");
    frm(rfe_pkg::K_STR16, 16'h8, 16'h1, '0, '0, "20ac",
        "1b56535508000100ac20");
    slow = 1'b0;
    req_is_float = 1'b1;
    frm(rfe_pkg::K_REGVAL, 16'h0a0b, '0, 32'h3f800000, '0, "",
        "1b5652470b0a46000000803f");
    req_is_float = 1'b0;
    frm(rfe_pkg::K_REGVAL, 16'h0a0b, '0, 32'h5, '0, "",
        "1b5652470b0a490005000000");
  endtask : s_str
  task automatic s_io;
    string rc [3] = '{"52", "53", "49"};
    frm(rfe_pkg::K_PORT_INV, '0, 16'h4, '0, '0, "",
        "1b4850490500");
    frm(rfe_pkg::K_PORT_RD, '0, '0, '0, 16'h0302, "00110022",
        "1b48505203021122");
    frm(rfe_pkg::K_PIN_RD, '0, '0, '0, 16'h0501, "0001",
        "1b484252050101");
    frm(rfe_pkg::K_ANA_RD, '0, '0, '0, 16'h0102, "0abc0123",
        "1b4841520102bc0a2301");
    foreach (rc[i])
      frm(rfe_pkg::rfe_kind_e'(5'(9 + i)), '0, '0, 32'h2, '0, "00aa0055",
          {"1b48", rc[i], "5202000000aa55"});
  endtask : s_io
  task s_time;
    tm = '{16'h0d, 16'h2d, 16'h11, 16'h09, 16'h06, 16'h07e8, 16'h0};
    frm(rfe_pkg::K_TIME_BIN, '0, '0, '0, '0, "",
        "1b5753420d002d00110009000600e8070000");
    frm(rfe_pkg::K_TIME_TXT, '0, '0, '0, '0, "0031",
        "1b5753413100");
    frm(rfe_pkg::K_TIME_WID, '0, '0, '0, '0, "0031",
        "1b57535531000000");
  endtask : s_time
  task s_dir;
    frm(rfe_pkg::K_WDIR, '0, '0, '0, '0, "002f0061",
        "1b4644472f6100");
    ent_size = 32'h12345678;
    ent_attr = 8'h20;
    stamp = {5'h0d, 6'h2d, 6'h3a, 7'h2c, 4'h6, 5'h09};
    lst = 1'b1;
    frm(rfe_pkg::K_DIR_LIST, '0, '0, '0, '0, "0078",
        "1b46445278007856341220bd6dc95800");
    lst = 1'b0;
  endtask : s_dir

  // reset for 16 cycles, then every scenario
  initial begin
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    s_sel();
    s_str();
    s_io();
    s_time();
    s_dir();
    test_done();
  end
endmodule : response_frame_encoder_test
